// ### adc_host.sv
// host end: result fifo and the select / clock / frame sync sequencer
`timescale 1ns/10ps
module result_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wr;
        logic [AW:0] rd;
    } fifo_regs_t;

    fifo_regs_t r;
    fifo_regs_t next_r;
    logic full;
    logic empty;

    assign empty = (r.wr == r.rd);
    assign full = (r.wr[AW-1:0] == r.rd[AW-1:0]) && (r.wr[AW] != r.rd[AW]);
    assign o_in_ready = ~full;
    assign o_out_valid = ~empty;
    assign o_out_data = r.mem[r.rd[AW-1:0]];

    always_comb begin
        next_r = r;
        if (i_in_valid && !full) begin
            next_r.mem[r.wr[AW-1:0]] = i_in_data;
            next_r.wr = r.wr + 1'b1;
        end
        if (i_out_ready && !empty) begin
            next_r.rd = r.rd + 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
endmodule : result_fifo

module adc_host #(
    parameter int HALF_CYCLES = adc_link_pkg::SCLK_HALF_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    adc_link_if.host link,
    input wire logic i_start,
    input wire logic i_mode_uc,
    input wire logic [adc_link_pkg::CNT_W-1:0] i_bits,
    output logic o_busy,
    output logic o_word_valid,
    input wire logic i_word_ready,
    output logic [adc_link_pkg::RESULT_BITS-1:0] o_word
);
    import adc_link_pkg::*;

    typedef struct packed {
        host_state_t state;
        logic mode_uc;
        logic [CNT_W-1:0] bits;
        logic cs_n;
        logic sclk;
        logic fs;
        logic [7:0] div;
        logic [7:0] cnt;
        logic [FRAME_BITS-1:0] shift;
        logic [1:0] do_s;
    } host_regs_t;

    localparam host_regs_t REGS_RESET = '{
        state: H_IDLE, mode_uc: 1'b0, bits: 5'h10, cs_n: 1'b1, sclk: 1'b0, fs: 1'b0,
        div: 8'h00, cnt: 8'h00, shift: 16'h0000, do_s: 2'h0
    };

    host_regs_t r;
    host_regs_t next_r;
    logic fifo_ready;
    logic push;

    assign push = (r.state == H_PUSH);

    always_comb begin
        logic tick;
        tick = (r.div == 8'(HALF_CYCLES - 1));
        next_r = r;
        next_r.do_s = {r.do_s[0], link.data_out};
        next_r.div = tick ? 8'h00 : r.div + 8'h01;
        case (r.state)
            H_IDLE: begin
                next_r.sclk = 1'b0; // R15
                if (i_start && fifo_ready) begin
                    next_r.mode_uc = i_mode_uc;
                    next_r.bits = (i_bits == 5'h00 || i_bits > 5'(FRAME_BITS)) ?
                        5'(FRAME_BITS) : i_bits; // R16 R20
                    next_r.fs = i_mode_uc;
                    next_r.cnt = 8'h00;
                    next_r.state = H_SETUP;
                end
            end
            H_SETUP: begin
                next_r.cnt = r.cnt + 8'h01;
                if (r.cnt == 8'(CS_SETUP_CYCLES - 1)) begin
                    next_r.cs_n = 1'b0;
                    next_r.cnt = 8'h00;
                    next_r.state = H_HOLD;
                end
            end
            H_HOLD: begin
                next_r.cnt = r.cnt + 8'h01;
                if (r.cnt == 8'(FS_HOLD_CYCLES - 1)) begin
                    // frame sync held at its mode level up to here
                    next_r.cnt = 8'h00; // R4
                    next_r.div = 8'h00;
                    next_r.fs = 1'b1; // R14
                    next_r.state = r.mode_uc ? H_CLOCK : H_FRAME;
                end
            end
            H_FRAME: begin
                if (tick) begin
                    next_r.sclk = ~r.sclk;
                    if (r.sclk) begin
                        next_r.fs = 1'b0;
                        next_r.state = H_CLOCK;
                    end
                end
            end
            H_CLOCK: begin
                if (tick) begin
                    next_r.sclk = ~r.sclk;
                    if (r.sclk) begin
                        next_r.shift = {r.shift[FRAME_BITS-2:0], r.do_s[1]};
                        next_r.cnt = r.cnt + 8'h01;
                        if (r.cnt == 8'(r.bits) - 8'h01) begin
                            next_r.cs_n = 1'b1; // R20
                            next_r.cnt = 8'h00;
                            next_r.state = H_END;
                        end
                    end
                end
            end
            H_END: begin
                next_r.cnt = r.cnt + 8'h01;
                if (r.cnt == 8'(CS_GAP_CYCLES - 1)) begin
                    next_r.state = H_PUSH;
                end
            end
            H_PUSH: begin
                if (fifo_ready) begin
                    next_r.state = H_IDLE;
                end
            end
            default: begin
                next_r.state = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            r <= REGS_RESET;
        end else begin
            r <= next_r;
        end
    end

    result_fifo #(.WIDTH(RESULT_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_in_valid(push),
        .o_in_ready(fifo_ready),
        .i_in_data(r.shift[RESULT_BITS-1:0]),
        .o_out_valid(o_word_valid),
        .i_out_ready(i_word_ready),
        .o_out_data(o_word)
    );

    assign link.cs_n = r.cs_n;
    assign link.sclk = r.sclk;
    assign link.frame_sync = r.fs;
    assign o_busy = (r.state != H_IDLE);
endmodule : adc_host

// ### adc_link_pkg.sv
// shared constants and types for the converter serial link
package adc_link_pkg;
    localparam int ZERO_BITS = 6;
    localparam int RESULT_BITS = 10;
    localparam int FRAME_BITS = 16;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] SAMPLE_END_EDGE = 5'h06;
    localparam logic [CNT_W-1:0] LAST_BIT_EDGE = 5'h10;
    localparam logic [CNT_W-1:0] TRISTATE_EDGE = 5'h11;
    localparam logic [2:0] MODE_LATCH_DELAY = 3'h2;
    localparam int CLK_PERIOD_NS = 4;
    localparam int SCLK_HALF_CYCLES = 8;
    localparam int CS_SETUP_CYCLES = 4;
    localparam int FS_HOLD_CYCLES = 8;
    localparam int CS_GAP_NS = 32;
    localparam int CS_GAP_CYCLES = (CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FIFO_DEPTH = 16;
    localparam logic [RESULT_BITS-1:0] RESULT_RESET = 10'h000;

    typedef enum logic [2:0] {
        D_OFF, D_LATCH, D_DSP_WAIT, D_DSP_RUN, D_DSP_PDOWN, D_UC_RUN
    } dev_state_t;

    typedef enum logic [2:0] {
        H_IDLE, H_SETUP, H_HOLD, H_FRAME, H_CLOCK, H_END, H_PUSH
    } host_state_t;

    // bit shown at position k of a frame: leading zeros, then result msb first
    function automatic logic frame_bit(input logic [RESULT_BITS-1:0] res,
                                       input logic [CNT_W-1:0] k);
        logic [CNT_W-1:0] idx;
        idx = 5'(FRAME_BITS - 1) - k;
        if (k < 5'(ZERO_BITS) || k > 5'(FRAME_BITS - 1)) begin
            return 1'b0;
        end
        return res[idx[3:0]];
    endfunction : frame_bit
endpackage : adc_link_pkg

// ### adc_link_if.sv
// serial link between the converter end and its host
`timescale 1ns/10ps
interface adc_link_if;
    logic cs_n;
    logic sclk;
    logic frame_sync;
    logic data_out;
    logic data_oe;

    modport device (input cs_n, input sclk, input frame_sync, output data_out, output data_oe);
    modport host (output cs_n, output sclk, output frame_sync, input data_out, input data_oe);
endinterface : adc_link_if

// ### adc_device.sv
// converter end: mode latch, framing, powerdown and serial result output
//
// How it works
// R1 - select high: output off, fully powered down
// R2 - select fall samples frame sync for mode
// R3 - two frame sync samples; both one means uc
// R4 - host holds frame sync after select falls
// R5 - dsp mode powered down until frame sync rises
// R6 - frame sync high at falling edge resets conversion
// R7 - six zeros then result on rising edges
// R8 - dsp sampling from first fall to sixth zero
// R9 - dsp powerdown on seventeenth falling edge
// R10 - dsp output off on seventeenth rising edge
// R11 - frame sync on bit sixteen gives back-to-back
// R12 - frame sync mid conversion restarts conversion
// R13 - select acts asynchronously to serial clock
// R14 - host may use async start pulse as sync
// R15 - uc mode clock idles low, phase one
// R16 - uc host gives sixteen clocks, select low
// R17 - uc conversion started by clock after select
// R18 - uc sampling ends at sixth zero edge
// R19 - uc powerdown on falling sixteen, wake seventeen
// R20 - short transfer: select high, fall restarts
// R21 - uc select fall only latches mode, drives output
// R22 - result bits go msb first
`timescale 1ns/10ps
module adc_device (
    input wire logic i_clk,
    input wire logic i_arst_n,
    adc_link_if.device link,
    input wire logic [adc_link_pkg::RESULT_BITS-1:0] i_result,
    output logic o_sample_done,
    output logic o_sampling,
    output logic o_powered_down,
    output logic o_mode_uc
);
    import adc_link_pkg::*;

    typedef struct packed {
        logic [1:0] cs_s;
        logic [1:0] sclk_s;
        logic [1:0] fs_s;
        logic cs_d;
        logic sclk_d;
        logic fs_d;
        dev_state_t state;
        logic mode_uc;
        logic latch_a;
        logic [2:0] lat_cnt;
        logic [CNT_W-1:0] rcnt;
        logic [RESULT_BITS-1:0] result;
        logic data;
        logic oe;
        logic sampling;
        logic pdown;
        logic sample_done;
    } dev_regs_t;

    localparam dev_regs_t REGS_RESET = '{
        cs_s: 2'h3, sclk_s: 2'h0, fs_s: 2'h0, cs_d: 1'b1, sclk_d: 1'b0, fs_d: 1'b0,
        state: D_OFF, mode_uc: 1'b0, latch_a: 1'b0, lat_cnt: 3'h0, rcnt: 5'h00,
        result: RESULT_RESET, data: 1'b0, oe: 1'b0, sampling: 1'b0, pdown: 1'b1,
        sample_done: 1'b0
    };

    dev_regs_t r;
    dev_regs_t next_r;

    always_comb begin
        logic cs;
        logic sclk;
        logic fs;
        logic rise;
        logic fall;
        logic fs_rise;
        cs = r.cs_s[1];
        sclk = r.sclk_s[1];
        fs = r.fs_s[1];
        rise = sclk & ~r.sclk_d;
        fall = ~sclk & r.sclk_d;
        fs_rise = fs & ~r.fs_d;
        next_r = r;
        next_r.cs_s = {r.cs_s[0], link.cs_n};
        next_r.sclk_s = {r.sclk_s[0], link.sclk};
        next_r.fs_s = {r.fs_s[0], link.frame_sync};
        next_r.cs_d = cs;
        next_r.sclk_d = sclk;
        next_r.fs_d = fs;
        next_r.sample_done = 1'b0;
        if (cs) begin
            next_r.state = D_OFF; // R1 R13 R20
            next_r.oe = 1'b0; // R1
            next_r.pdown = 1'b1; // R1
            next_r.sampling = 1'b0;
            next_r.rcnt = '0;
        end else begin
            case (r.state)
                D_OFF: begin
                    // only a select fall can bring us here with select low
                    next_r.latch_a = fs; // R2 R3
                    next_r.lat_cnt = 3'h0;
                    next_r.state = D_LATCH;
                end
                D_LATCH: begin
                    next_r.lat_cnt = r.lat_cnt + 3'h1;
                    if (r.lat_cnt == MODE_LATCH_DELAY - 3'h1) begin
                        next_r.mode_uc = r.latch_a & fs; // R3
                        if (r.latch_a & fs) begin
                            next_r.state = D_UC_RUN; // R21
                            next_r.oe = 1'b1; // R21
                            next_r.data = 1'b0;
                            next_r.rcnt = '0;
                        end else begin
                            next_r.state = D_DSP_WAIT; // R5
                        end
                    end
                end
                D_DSP_WAIT, D_DSP_PDOWN, D_DSP_RUN: begin
                    if (fall && fs) begin
                        // frame sync seen: restart whatever was in flight
                        next_r.state = D_DSP_RUN; // R6 R11 R12
                        next_r.rcnt = '0; // R6
                        next_r.data = 1'b0;
                        next_r.oe = 1'b1;
                        next_r.pdown = 1'b0;
                        next_r.sampling = 1'b0;
                    end else if (fs_rise && r.state != D_DSP_RUN) begin
                        next_r.state = D_DSP_RUN; // R5 R9
                        next_r.rcnt = '0;
                        next_r.data = 1'b0;
                        next_r.oe = 1'b1; // R10
                        next_r.pdown = 1'b0; // R5 R9
                    end else if (r.state == D_DSP_RUN) begin
                        // first fall after frame sync drops opens sampling, even after bit 0
                        if (fall && !fs && r.rcnt < SAMPLE_END_EDGE) begin
                            next_r.sampling = 1'b1; // R8
                        end else if (fall && r.rcnt == TRISTATE_EDGE) begin
                            next_r.pdown = 1'b1; // R9
                            next_r.state = D_DSP_PDOWN; // R9
                        end
                        if (rise && !fs && r.rcnt != TRISTATE_EDGE) begin
                            next_r.rcnt = r.rcnt + 5'h01; // R7
                            next_r.data = frame_bit(r.result, r.rcnt); // R7 R22
                            if (r.rcnt + 5'h01 == SAMPLE_END_EDGE) begin
                                next_r.sampling = 1'b0; // R8
                                next_r.result = i_result;
                                next_r.sample_done = 1'b1;
                            end
                            if (r.rcnt + 5'h01 == TRISTATE_EDGE) begin
                                next_r.oe = 1'b0; // R10
                                next_r.data = 1'b0;
                            end
                        end
                    end
                end
                D_UC_RUN: begin
                    if (rise) begin
                        if (r.rcnt == 5'h00 || r.rcnt == LAST_BIT_EDGE) begin
                            // first clock, or the seventeenth: new conversion
                            next_r.rcnt = 5'h01; // R17 R19
                            next_r.pdown = 1'b0; // R19
                            next_r.sampling = 1'b1; // R17
                            next_r.data = 1'b0; // R7
                        end else begin
                            next_r.rcnt = r.rcnt + 5'h01;
                            next_r.data = frame_bit(r.result, r.rcnt); // R7 R22
                            if (r.rcnt + 5'h01 == SAMPLE_END_EDGE) begin
                                next_r.sampling = 1'b0; // R18
                                next_r.result = i_result; // R18
                                next_r.sample_done = 1'b1;
                            end
                        end
                    end else if (fall && r.rcnt == LAST_BIT_EDGE) begin
                        next_r.pdown = 1'b1; // R19
                    end
                end
                default: begin
                    next_r.state = D_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            r <= REGS_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign link.data_out = r.data;
    assign link.data_oe = r.oe & ~r.cs_s[1]; // R13
    assign o_sample_done = r.sample_done;
    assign o_sampling = r.sampling;
    assign o_powered_down = r.pdown;
    assign o_mode_uc = r.mode_uc;
endmodule : adc_device

// ### adc_link_asserts.sv
// checker for select, clock and data relations on the converter serial link
`timescale 1ns/10ps
module adc_link_asserts (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic frame_sync,
    input wire logic data_out,
    input wire logic data_oe
);
    logic uc;
    logic [4:0] rcnt;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    // mode seen at select fall, and counted rising clock edges of the frame
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            uc <= 1'h0;
            rcnt <= 5'h00;
        end else begin
            if ($fell(cs_n)) begin
                uc <= frame_sync;
            end
            if (cs_n || ($fell(sclk) && frame_sync && !uc)) begin
                rcnt <= 5'h00;
            end else if ($rose(sclk) && (uc || !frame_sync)) begin
                rcnt <= rcnt + 5'h01;
            end
        end
    end
    sequence s_fall_in_frame;
        $fell(sclk) && data_oe && !cs_n;
    endsequence
    sequence s_lead_zero;
        s_fall_in_frame ##0 (rcnt >= 5'h01 && rcnt <= 5'h06);
    endsequence
    property p_off_deselected; cs_n [*5] |-> !data_oe; endproperty
    property p_deselect_fast; $rose(cs_n) |-> ##[1:5] !data_oe; endproperty
    property p_sclk_idle; cs_n |-> !sclk; endproperty
    property p_fs_hold; $fell(cs_n) |-> $stable(frame_sync) [*6]; endproperty
    property p_dsp_quiet; $fell(cs_n) && !frame_sync |-> !data_oe [*6]; endproperty
    property p_dsp_wake; !uc && !cs_n && $rose(frame_sync) |-> ##[1:8] data_oe; endproperty
    property p_uc_drive; $fell(cs_n) && frame_sync |-> ##[2:10] data_oe; endproperty
    property p_lead_zero; s_lead_zero |-> !data_out; endproperty
    property p_hold_at_fall; s_fall_in_frame |-> $stable(data_out) [*2]; endproperty
    a_off_deselected: assert property (p_off_deselected)
        else $error("output driven while deselected");
    a_deselect_fast: assert property (p_deselect_fast)
        else $error("output not released after select rose");
    a_sclk_idle: assert property (p_sclk_idle)
        else $error("serial clock high while deselected");
    a_fs_hold: assert property (p_fs_hold)
        else $error("frame sync moved during mode latch");
    a_dsp_quiet: assert property (p_dsp_quiet)
        else $error("dsp output driven before frame sync");
    a_dsp_wake: assert property (p_dsp_wake)
        else $error("dsp output not driven after frame sync rose");
    a_uc_drive: assert property (p_uc_drive)
        else $error("uc output not driven after select fell");
    a_lead_zero: assert property (p_lead_zero)
        else $error("leading bit not zero");
    a_hold_at_fall: assert property (p_hold_at_fall)
        else $error("data changed at capture edge");
endmodule : adc_link_asserts

// ### test_serial_adc_frame_control.sv
// bench: host and converter ends joined, plus a converter driven directly
`timescale 1ns/10ps
module test_serial_adc_frame_control;
    import adc_link_pkg::*;
    typedef struct packed {
        logic uc;
        logic [4:0] n;
        logic [15:0] v;
    } note_t;
    logic i_clk = 1'h0;
    logic i_arst_n = 1'h0;
    logic start = 1'h0;
    logic mode_uc = 1'h0;
    logic [4:0] nbits = 5'h10;
    logic word_ready = 1'h0;
    logic stall = 1'h0;
    logic [9:0] res1 = 10'h000;
    logic [9:0] res2 = 10'h000;
    logic busy, word_valid, pd2, mu2, armed, smp2;
    logic [9:0] word;
    logic [15:0] cap, cap2;
    logic [4:0] cnt;
    logic ps = 1'h0;
    logic pcs = 1'h1;
    logic [4:0] lens [5] = '{5'h10, 5'h0e, 5'h0a, 5'h00, 5'h14};
    logic [9:0] wq[$];
    note_t fq[$];
    int mismatches = 0;
    int total_checks = 0;
    adc_link_if lk();
    adc_link_if lk2();
    adc_device i_adc_device (.i_clk(i_clk), .i_arst_n(i_arst_n), .link(lk), .i_result(res1),
        .o_sample_done(), .o_sampling(), .o_powered_down(), .o_mode_uc());
    adc_device i_adc_device_b (.i_clk(i_clk), .i_arst_n(i_arst_n), .link(lk2), .i_result(res2),
        .o_sample_done(), .o_sampling(smp2), .o_powered_down(pd2), .o_mode_uc(mu2));
    adc_host i_adc_host (.i_clk(i_clk), .i_arst_n(i_arst_n), .link(lk), .i_start(start),
        .i_mode_uc(mode_uc), .i_bits(nbits), .o_busy(busy), .o_word_valid(word_valid),
        .i_word_ready(word_ready), .o_word(word));
    adc_link_asserts i_adc_link_asserts (.i_clk(i_clk), .i_arst_n(i_arst_n), .cs_n(lk.cs_n),
        .sclk(lk.sclk), .frame_sync(lk.frame_sync), .data_out(lk.data_out),
        .data_oe(lk.data_oe));
    initial begin
        forever #2 i_clk = ~i_clk;
    end
    task automatic tick(input int k);
        repeat (k) @(posedge i_clk);
        #1;
    endtask : tick
    task automatic check_vec(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : check_vec
    task automatic check_bit(input logic got, input logic exp);
        check_vec({15'h0000, got}, {15'h0000, exp});
    endtask : check_bit
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up
    task automatic wait_busy(input logic v);
        int k;
        k = 0;
        while (busy !== v && k < 3000) begin
            tick(1);
            k++;
        end
        check_bit(busy, v);
    endtask : wait_busy
    task automatic wait_empty();
        int k;
        k = 0;
        while (wq.size() > 0 && k < 6000) begin
            tick(1);
            k++;
        end
        tick(2);
        check_vec(16'(wq.size()), 16'h0000);
    endtask : wait_empty
    // host transfer: notes the expected word and wire frame
    task automatic xfer(input logic uc, input logic [4:0] bits);
        int n;
        logic [15:0] e;
        n = (bits == 5'h00 || bits > 5'h10) ? 16 : int'(bits);
        res1 = 10'($urandom);
        e = {6'h00, res1} >> (16 - n);
        mode_uc = uc;
        nbits = bits;
        wq.push_back(e[9:0]);
        fq.push_back(note_t'{uc, 5'(n), e});
        start = 1'h1;
        wait_busy(1'h1);
        start = 1'h0;
        wait_busy(1'h0);
    endtask : xfer
    task automatic sel(input logic a, input logic b);
        lk2.cs_n = 1'h1;
        tick(8);
        lk2.frame_sync = a;
        tick(2);
        lk2.cs_n = 1'h0;
        tick(1);
        lk2.frame_sync = b;
        tick(12);
    endtask : sel
    task automatic sck(input int n);
        repeat (n) begin
            lk2.sclk = 1'h1;
            tick(8);
            cap2 = {cap2[14:0], lk2.data_oe ? lk2.data_out : ~lk2.data_out};
            lk2.sclk = 1'h0;
            tick(8);
        end
    endtask : sck
    // frame sync rises inside the high phase, so that rising edge still shifts a bit
    task automatic pulse();
        lk2.sclk = 1'h1;
        tick(4);
        lk2.frame_sync = 1'h1;
        tick(4);
        cap2 = {cap2[14:0], lk2.data_oe ? lk2.data_out : ~lk2.data_out};
        lk2.sclk = 1'h0;
        tick(8);
        lk2.frame_sync = 1'h0;
    endtask : pulse
    always @(posedge i_clk) begin
        if (word_valid === 1'h1 && word_ready === 1'h1) begin
            check_vec({6'h00, word}, wq.size() > 0 ? {6'h00, wq.pop_front()} : 16'hffff);
        end
        word_ready <= #1 stall ? 1'h0 : 1'($urandom);
    end
    // wire view of the joined link: bits captured where the host captures them
    always @(posedge i_clk) begin
        if (pcs && !lk.cs_n) begin
            cap = 16'h0000;
            cnt = 5'h00;
            armed = 1'h0;
        end
        if (!ps && lk.sclk && fq.size() > 0 && (fq[0].uc || !lk.frame_sync)) begin
            armed = 1'h1;
        end
        if (ps && !lk.sclk && armed) begin
            cap = {cap[14:0], lk.data_oe ? lk.data_out : ~lk.data_out};
            cnt++;
            armed = 1'h0;
        end
        if (!pcs && lk.cs_n && fq.size() > 0) begin
            check_vec(cap, fq[0].v);
            check_vec(16'(cnt), 16'(fq[0].n));
            void'(fq.pop_front());
        end
        ps = lk.sclk;
        pcs = lk.cs_n;
    end
    initial begin
        repeat (60000) @(posedge i_clk);
        mismatches++;
        $display("mismatch at %0t: run did not finish", $time);
        wrap_up();
    end
    initial begin
        lk2.cs_n = 1'h1;
        lk2.sclk = 1'h0;
        lk2.frame_sync = 1'h0;
        void'($urandom(78));
        tick(10);
        i_arst_n = 1'h1;
        tick(2);
        for (int m = 0; m < 2; m++) begin
            foreach (lens[j]) begin
                xfer(1'(m), lens[j]);
            end
        end
        wait_empty();
        stall = 1'h1;
        repeat (FIFO_DEPTH) xfer(1'h1, 5'h10);
        start = 1'h1;
        tick(40);
        check_bit(busy, 1'h0);
        start = 1'h0;
        check_bit(word_valid, 1'h1);
        stall = 1'h0;
        wait_empty();
        check_bit(word_valid, 1'h0);
        for (int c = 0; c < 4; c++) begin
            sel(c[1], c[0]);
            check_bit(mu2, c == 3);
            if (c != 1) begin
                check_bit(lk2.data_oe, c == 3);
            end
            if (c == 0 || c == 2) begin
                check_bit(pd2, 1'h1);
            end
        end
        sel(1'h0, 1'h0);
        res2 = 10'($urandom);
        pulse();
        sck(15);
        pulse();
        check_vec(cap2, {6'h00, res2});
        sck(5);
        check_bit(smp2, 1'h1);
        pulse();
        sck(16);
        check_vec(cap2, {6'h00, res2});
        check_bit(smp2, 1'h0);
        check_bit(pd2, 1'h0);
        lk2.sclk = 1'h1;
        tick(8);
        check_bit(lk2.data_oe, 1'h0);
        lk2.sclk = 1'h0;
        tick(8);
        check_bit(pd2, 1'h1);
        lk2.frame_sync = 1'h1;
        tick(8);
        check_bit(lk2.data_oe, 1'h1);
        check_bit(pd2, 1'h0);
        res2 = 10'($urandom);
        sel(1'h1, 1'h1);
        sck(16);
        check_vec(cap2, {6'h00, res2});
        check_bit(pd2, 1'h1);
        lk2.sclk = 1'h1;
        tick(8);
        check_bit(pd2, 1'h0);
        lk2.cs_n = 1'h1;
        tick(6);
        check_bit(lk2.data_oe, 1'h0);
        check_bit(pd2, 1'h1);
        lk2.sclk = 1'h0;
        tick(4);
        wrap_up();
    end
endmodule : test_serial_adc_frame_control
